/* logic/alsc_pkg.sv */
`default_nettype none
package alsc_pkg;
	localparam logic [9:0] OFS_MODE       = 10'h008;
	localparam logic [9:0] OFS_ICA        = 10'h010;
	localparam logic [9:0] OFS_OCA        = 10'h014;
	localparam logic [9:0] OFS_CA_RX      = 10'h020;
	localparam logic [9:0] OFS_CA_TX      = 10'h024;
	localparam logic [9:0] OFS_CB_RX      = 10'h030;
	localparam logic [9:0] OFS_CB_TX      = 10'h034;
	localparam logic [9:0] OFS_CB_STAT    = 10'h038;
	localparam logic [9:0] OFS_CB_MODE    = 10'h03C;
	localparam logic [9:0] OFS_CO_RX      = 10'h040;
	localparam logic [9:0] OFS_CO_TX      = 10'h044;
	localparam logic [9:0] OFS_CO_STAT    = 10'h048;
	localparam logic [9:0] OFS_CO_MODE    = 10'h04C;
	localparam logic [9:0] OFS_GSTAT      = 10'h050;
	localparam logic [9:0] OFS_IRQ_SET    = 10'h054;
	localparam logic [9:0] OFS_IRQ_CLR    = 10'h058;
	localparam logic [9:0] OFS_IRQ_MASK   = 10'h05C;
	localparam logic [9:0] OFS_DMA_LO     = 10'h100;
	localparam logic [9:0] OFS_DMA_HI     = 10'h124;
	localparam int         BIT_ON         = 0;
	localparam int         BIT_WARM       = 1;
	localparam int         BIT_VRATE      = 2;
	localparam int         SEL_W          = 3;
	localparam int         FIRST_SLOT     = 3;
	localparam int         NUM_SLOTS      = 10;
	localparam logic [2:0] SEL_NONE       = 3'h0;
	localparam logic [2:0] SEL_A          = 3'h1;
	localparam logic [2:0] SEL_B          = 3'h2;
	localparam int         CO_READ_BIT    = 23;
	localparam int         ST_SOF         = 0;
	localparam int         ST_CO_RDY      = 1;
	localparam int         ST_CA_RDY      = 2;
	localparam int         ST_CB_RDY      = 3;
	localparam int         ST_W           = 4;
	localparam logic [31:0] RST_REG       = 32'h0000_0000;
	localparam int         SLOT0_BITS     = 16;
	localparam int         SLOT_BITS      = 20;
	localparam int         FRAME_BITS     = 256;
	localparam int         WARM_NS        = 1000;
	localparam int         CLK_NS         = 10;
	localparam int         WARM_CYC       = (WARM_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

/* logic/alsc_top.sv */
// Chosen here: the strobed register port.
`default_nettype none
// Overview of operation
// R01 - Variable-rate bit 0: slots 3-12 run every frame; 1: slots need codec request.
// R02 - Warm restart output follows mode bit 1 while it holds 1.
// R03 - Enable bit 0 disables the link and blocks other registers.
// R04 - Writing enable bit 1 activates link and register access.
// R05 - Input slot map: 3-bit selectors, slot 3 at bit 0, slot 12 ends bit 29.
// R06 - Input selector 0 captures nothing in that slot.
// R07 - Input selector 1 routes slot data to receive channel A.
// R08 - Input selector 2 routes slot data to receive channel B.
// R09 - Output slot map uses the same packing as the input map.
// R10 - Output selector 0 sends no channel data in that slot.
// R11 - Output selector 1 sends transmit channel A data.
// R12 - Output selector 2 sends transmit channel B data.
// R13 - Offsets 0x100-0x124 are reserved for the channel A DMA registers.
// R14 - Frame sync held high while warm restart set, software keeps it 1 us.
// R15 - Codec command: flag and index in slot 1, data in slot 2.
// R16 - Codec status word captured from input slot 2.
// R17 - Enable register sets mask bits, disable register clears them.
// R18 - Interrupt high while any status flag and its mask bit are set.
module alsc_top
	import alsc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [9:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	input  wire logic        link_bit_clk,
	input  wire logic        link_rx,
	output logic             link_tx,
	output logic             frame_sync_line,
	output logic             warm_restart_out,
	output logic             dma_sel
);
	// ----------------------------------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------------------------------
	logic       rst_s1_q;
	logic       rst_n_q;
	logic [1:0] bclk_s_q;
	logic [1:0] rx_s_q;
	logic       bclk_prev_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bclk_s_q    <= 2'h0;
			rx_s_q      <= 2'h0;
			bclk_prev_q <= 1'b0;
		end else begin
			bclk_s_q    <= {bclk_s_q[0], link_bit_clk};
			rx_s_q      <= {rx_s_q[0], link_rx};
			bclk_prev_q <= bclk_s_q[1];
		end
	end
	logic bclk_rise;
	logic bclk_fall;
	assign bclk_rise = bclk_s_q[1] & ~bclk_prev_q;
	assign bclk_fall = ~bclk_s_q[1] & bclk_prev_q;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [2:0]           mode_q;
	logic [29:0]          ica_q;
	logic [29:0]          oca_q;
	logic [19:0]          ca_tx_q;
	logic [19:0]          cb_tx_q;
	logic [23:0]          co_tx_q;
	logic                 ca_tx_vld_q;
	logic                 cb_tx_vld_q;
	logic                 co_tx_vld_q;
	logic [ST_W-1:0]      imask_q;
	logic                 wr_ok;
	logic                 rd_ok;
	logic                 take_ca;
	logic                 take_cb;
	logic                 take_co;
	// R03 block access when off
	assign wr_ok = reg_wr & (mode_q[BIT_ON] | reg_addr == OFS_MODE);
	assign rd_ok = reg_rd & (mode_q[BIT_ON] | reg_addr == OFS_MODE);
	// R13 DMA window decode
	assign dma_sel = (reg_wr | reg_rd) & mode_q[BIT_ON]
		& reg_addr >= OFS_DMA_LO & reg_addr <= OFS_DMA_HI;

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= 3'h0;
			ica_q  <= RST_REG[29:0];
			oca_q  <= RST_REG[29:0];
		end else if (wr_ok) begin
			// R04 enable write
			if (reg_addr == OFS_MODE)
				mode_q <= reg_wdata[2:0];
			// R05 input map
			if (reg_addr == OFS_ICA)
				ica_q <= reg_wdata[29:0];
			// R09 output map
			if (reg_addr == OFS_OCA)
				oca_q <= reg_wdata[29:0];
		end
	end

	// R17 mask set and clear
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			imask_q <= RST_REG[ST_W-1:0];
		end else if (wr_ok && reg_addr == OFS_IRQ_SET) begin
			imask_q <= imask_q | reg_wdata[ST_W-1:0];
		end else if (wr_ok && reg_addr == OFS_IRQ_CLR) begin
			imask_q <= imask_q & ~reg_wdata[ST_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Frame timing on the sampled bit clock
	// ----------------------------------------------------------------
	logic [7:0] bit_cnt_q;
	logic       link_on;
	logic [3:0] slot_idx;
	logic [4:0] slot_bit;
	logic       slot_last;
	logic [7:0] rel;
	// R03 link gated by enable
	assign link_on = mode_q[BIT_ON];
	always_comb begin
		if (bit_cnt_q < 8'(SLOT0_BITS)) begin
			slot_idx = 4'h0;
			slot_bit = bit_cnt_q[4:0];
			rel      = 8'h00;
		end else begin
			rel      = bit_cnt_q - 8'(SLOT0_BITS);
			slot_idx = 4'(rel / 8'(SLOT_BITS)) + 4'h1;
			slot_bit = 5'(rel % 8'(SLOT_BITS));
		end
	end
	assign slot_last  = (slot_idx == 4'h0) ? (slot_bit == 5'(SLOT0_BITS - 1))
		: (slot_bit == 5'(SLOT_BITS - 1));

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			bit_cnt_q <= 8'h00;
		else if (!link_on)
			bit_cnt_q <= 8'h00;
		else if (bclk_rise)
			bit_cnt_q <= (bit_cnt_q == 8'(FRAME_BITS - 1)) ? 8'h00 : bit_cnt_q + 8'h01;
	end

	// R02 warm restart signal
	assign warm_restart_out = mode_q[BIT_WARM];
	// R14 sync held high in warm restart
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			frame_sync_line <= 1'b0;
		else if (mode_q[BIT_WARM])
			frame_sync_line <= 1'b1;
		else if (!link_on)
			frame_sync_line <= 1'b0;
		else if (bclk_rise)
			frame_sync_line <= (bit_cnt_q == 8'(FRAME_BITS - 1))
				| (bit_cnt_q < 8'(SLOT0_BITS - 1));
	end

	// ----------------------------------------------------------------
	// Slot selectors and request tags
	// ----------------------------------------------------------------
	logic [2:0] in_sel;
	logic [3:0] dslot;
	logic       slot_req_q;
	assign dslot = slot_idx - 4'(FIRST_SLOT);
	always_comb begin
		in_sel  = SEL_NONE;
		if (slot_idx >= 4'(FIRST_SLOT)) begin
			in_sel  = ica_q[dslot*SEL_W +: SEL_W];
		end
	end

	// R01 slot request in variable rate
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			slot_req_q <= 1'b1;
		else if (bclk_fall && slot_idx == 4'h0 && slot_bit == 5'h00)
			slot_req_q <= 1'b1;
		else if (bclk_fall && slot_idx == 4'h0 && mode_q[BIT_VRATE])
			slot_req_q <= slot_req_q;
		else if (bclk_fall && slot_idx == 4'h1 && slot_bit == 5'(8) && mode_q[BIT_VRATE])
			slot_req_q <= ~rx_s_q[1];
	end

	// ----------------------------------------------------------------
	// Transmit shifter
	// ----------------------------------------------------------------
	logic [19:0] tx_sh_q;
	logic        tx_frame_tag_q;
	logic [7:0]  nxt_cnt;
	logic [7:0]  nxt_rel;
	logic [3:0]  nxt_idx;
	logic        nxt_start;
	logic [2:0]  nxt_out_sel;
	logic [19:0] tx_word;
	// Bit that the next bit clock rise puts on the line
	assign nxt_cnt = (bit_cnt_q == 8'(FRAME_BITS - 1)) ? 8'h00 : bit_cnt_q + 8'h01;
	always_comb begin
		nxt_rel     = nxt_cnt - 8'(SLOT0_BITS);
		nxt_idx     = 4'h0;
		nxt_start   = (nxt_cnt == 8'h00);
		nxt_out_sel = SEL_NONE;
		if (nxt_cnt >= 8'(SLOT0_BITS)) begin
			nxt_idx   = 4'(nxt_rel / 8'(SLOT_BITS)) + 4'h1;
			nxt_start = (nxt_rel % 8'(SLOT_BITS)) == 8'h00;
		end
		if (nxt_idx >= 4'(FIRST_SLOT))
			nxt_out_sel = oca_q[(nxt_idx - 4'(FIRST_SLOT))*SEL_W +: SEL_W];
	end

	always_comb begin
		tx_word = 20'h00000;
		if (nxt_idx == 4'h0) begin
			tx_word = {1'b1, 1'b0, co_tx_vld_q, 1'b0,
				ca_tx_vld_q | cb_tx_vld_q, 15'h0000};
		end else if (nxt_idx == 4'h1 && tx_frame_tag_q) begin
			// R15 flag and index
			tx_word = {co_tx_q[CO_READ_BIT], co_tx_q[22:16], 12'h000};
		end else if (nxt_idx == 4'h2 && tx_frame_tag_q) begin
			// R15 command data
			tx_word = {co_tx_q[15:0], 4'h0};
		end else if (slot_req_q) begin
			// R10 R11 R12 output routing
			case (nxt_out_sel)
				SEL_A:   tx_word = ca_tx_q;
				SEL_B:   tx_word = cb_tx_q;
				default: tx_word = 20'h00000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_sh_q        <= 20'h00000;
			link_tx        <= 1'b0;
			tx_frame_tag_q <= 1'b0;
		end else if (!link_on) begin
			tx_sh_q <= 20'h00000;
			link_tx <= 1'b0;
		end else if (bclk_rise) begin
			// First bit leaves with the load, in line with sync
			if (nxt_start) begin
				link_tx <= tx_word[19];
				tx_sh_q <= {tx_word[18:0], 1'b0};
				if (nxt_idx == 4'h0)
					tx_frame_tag_q <= co_tx_vld_q;
			end else begin
				link_tx <= tx_sh_q[19];
				tx_sh_q <= {tx_sh_q[18:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive shifter and holding registers
	// ----------------------------------------------------------------
	logic [19:0]     rx_sh_q;
	logic [19:0]     ca_rx_q;
	logic [19:0]     cb_rx_q;
	logic [15:0]     co_rx_q;
	logic [ST_W-1:0] stat_q;
	logic [ST_W-1:0] ev;
	logic [19:0]     rx_word;
	assign rx_word = {rx_sh_q[18:0], rx_s_q[1]};
	always_comb begin
		ev = '0;
		if (link_on && bclk_fall && slot_last) begin
			ev[ST_SOF]    = (slot_idx == 4'h0);
			ev[ST_CO_RDY] = (slot_idx == 4'h2);
			ev[ST_CA_RDY] = slot_req_q & (in_sel == SEL_A);
			ev[ST_CB_RDY] = slot_req_q & (in_sel == SEL_B);
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_sh_q <= 20'h00000;
			ca_rx_q <= 20'h00000;
			cb_rx_q <= 20'h00000;
			co_rx_q <= 16'h0000;
		end else if (link_on && bclk_fall) begin
			rx_sh_q <= rx_word;
			// R16 status word capture
			if (ev[ST_CO_RDY])
				co_rx_q <= rx_word[19:4];
			// R07 route to channel A
			if (ev[ST_CA_RDY])
				ca_rx_q <= rx_word;
			// R08 route to channel B
			if (ev[ST_CB_RDY])
				cb_rx_q <= rx_word;
			// R06 selector zero ignored
		end
	end

	// Transmit holding registers
	assign take_ca = link_on & bclk_rise & nxt_start & slot_req_q & nxt_out_sel == SEL_A;
	assign take_cb = link_on & bclk_rise & nxt_start & slot_req_q & nxt_out_sel == SEL_B;
	assign take_co = link_on & bclk_rise & nxt_start & nxt_idx == 4'h2 & tx_frame_tag_q;
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ca_tx_q     <= 20'h00000;
			cb_tx_q     <= 20'h00000;
			co_tx_q     <= 24'h000000;
			ca_tx_vld_q <= 1'b0;
			cb_tx_vld_q <= 1'b0;
			co_tx_vld_q <= 1'b0;
		end else begin
			if (wr_ok && reg_addr == OFS_CA_TX) begin
				ca_tx_q     <= reg_wdata[19:0];
				ca_tx_vld_q <= 1'b1;
			end else if (take_ca)
				ca_tx_vld_q <= 1'b0;
			if (wr_ok && reg_addr == OFS_CB_TX) begin
				cb_tx_q     <= reg_wdata[19:0];
				cb_tx_vld_q <= 1'b1;
			end else if (take_cb)
				cb_tx_vld_q <= 1'b0;
			if (wr_ok && reg_addr == OFS_CO_TX) begin
				co_tx_q     <= reg_wdata[23:0];
				co_tx_vld_q <= 1'b1;
			end else if (take_co)
				co_tx_vld_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Status, interrupt and read port
	// ----------------------------------------------------------------
	logic stat_rd;
	assign stat_rd = rd_ok && reg_addr == OFS_GSTAT;
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			stat_q <= '0;
		else if (stat_rd)
			stat_q <= ev;
		else
			stat_q <= stat_q | ev;
	end
	// R18 masked interrupt
	assign irq = |(stat_q & imask_q);

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= 32'h0000_0000;
		end else if (rd_ok) begin
			case (reg_addr)
				OFS_MODE:     reg_rdata <= {29'h0, mode_q};
				OFS_ICA:      reg_rdata <= {2'h0, ica_q};
				OFS_OCA:      reg_rdata <= {2'h0, oca_q};
				OFS_CA_RX:    reg_rdata <= {12'h000, ca_rx_q};
				OFS_CB_RX:    reg_rdata <= {12'h000, cb_rx_q};
				OFS_CO_RX:    reg_rdata <= {16'h0000, co_rx_q};
				OFS_CB_STAT:  reg_rdata <= {31'h0, ~cb_tx_vld_q};
				OFS_CO_STAT:  reg_rdata <= {31'h0, ~co_tx_vld_q};
				OFS_GSTAT:    reg_rdata <= {28'h0, stat_q};
				OFS_IRQ_MASK: reg_rdata <= {28'h0, imask_q};
				default:      reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

/* testbench/alsc_top_asserts.sv */
`default_nettype none
module alsc_top_asserts
	import alsc_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [9:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        irq,
	input wire logic        link_bit_clk,
	input wire logic        link_rx,
	input wire logic        link_tx,
	input wire logic        frame_sync_line,
	input wire logic        warm_restart_out,
	input wire logic        dma_sel
);
	// ----------
	// Register mirror
	// ----------
	logic [2:0]      mode_q;
	logic [ST_W-1:0] mask_q;
	logic [5:0]      off_q;
	wire logic       dma_hit = (reg_wr | reg_rd) & mode_q[0]
		& (reg_addr >= OFS_DMA_LO) & (reg_addr <= OFS_DMA_HI);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 3'h0;
		end else if (reg_wr && reg_addr == OFS_MODE) begin
			mode_q <= reg_wdata[2:0];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (reg_wr && mode_q[0] && reg_addr == OFS_IRQ_SET) begin
			mask_q <= mask_q | reg_wdata[ST_W-1:0];
		end else if (reg_wr && mode_q[0] && reg_addr == OFS_IRQ_CLR) begin
			mask_q <= mask_q & ~reg_wdata[ST_W-1:0];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			off_q <= 6'h00;
		end else begin
			off_q <= mode_q[0] ? 6'h00 : (off_q == 6'h3F ? off_q : off_q + 6'h01);
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_rd_any(logic [9:0] a);
		reg_rd && reg_addr == a;
	endsequence
	sequence s_rd_on(logic [9:0] a);
		s_rd_any(a) ##0 mode_q[0];
	endsequence
	a_mode_read:
	assert property (s_rd_any(OFS_MODE) |=> reg_rdata[2:0] == $past(mode_q))
		else $error("mode readback wrong");
	a_mask_read:
	assert property (s_rd_on(OFS_IRQ_MASK) |=> reg_rdata == 32'($past(mask_q)))
		else $error("mask readback wrong");
	a_blocked_read:
	assert property (reg_rd && !mode_q[0] && reg_addr != OFS_MODE |=> reg_rdata == 32'h0)
		else $error("read not blocked while off");
	a_warm_level:
	assert property (warm_restart_out == mode_q[BIT_WARM])
		else $error("warm restart level wrong");
	a_sync_warm:
	assert property (warm_restart_out [*3] |-> frame_sync_line)
		else $error("frame sync low during warm restart");
	a_dma_decode:
	assert property (dma_sel == dma_hit)
		else $error("dma select decode wrong");
	a_irq_masked:
	assert property (mask_q == '0 |-> !irq)
		else $error("interrupt while fully masked");
	a_off_quiet:
	assert property (off_q == 6'h3F |-> !link_tx)
		else $error("link active while off");
endmodule
bind alsc_top alsc_top_asserts chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .irq, .link_bit_clk, .link_rx, .link_tx, .frame_sync_line, .warm_restart_out,
	.dma_sel);
`default_nettype wire

/* testbench/alsc_codec_model.sv */
`default_nettype none
module alsc_codec_model #(
	parameter logic [15:0] STATUS_WORD = 16'h5AC3
) (
	output logic         link_bit_clk,
	output logic         link_rx,
	input  wire logic    link_tx,
	input  wire logic    frame_sync_line,
	input  wire logic    warm_restart_out,
	input  wire logic    clr,
	output logic [239:0] acc
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------
	// Codec side
	// ----------
	logic [7:0] pos = 8'h00;
	logic [7:0] p;
	logic       sync_q = 1'h0;
	logic       bclk_q = 1'h0;
	logic       rx_q = 1'h0;
	function automatic logic rx_bit(logic [7:0] b);
		int          k;
		logic [19:0] w;
		if (b < 8'h10) return b < 8'h0D;
		k = (b - 16) / 20 + 1;
		w = k == 2 ? {STATUS_WORD, 4'h0} : (k == 1 ? 20'h00000 : {4'h9, 16'(k * 16'h1111)});
		return w[19 - (b - 16) % 20];
	endfunction
	assign link_bit_clk = bclk_q;
	assign link_rx      = rx_q;
	always #62.5 bclk_q = warm_restart_out ? 1'h0 : ~bclk_q;
	always @(negedge bclk_q or posedge clr) begin
		if (clr) begin
			acc <= '0;
		end else begin
			p = (frame_sync_line && !sync_q) ? 8'h00 : pos + 8'h01;
			sync_q <= frame_sync_line;
			pos <= p;
			if (p >= 8'h10) acc[8'hFF - p] <= acc[8'hFF - p] | link_tx;
		end
	end
	always @(posedge bclk_q) begin
		rx_q <= rx_bit(pos + 8'h01);
	end
endmodule
`default_nettype wire

/* testbench/tb_audio_link_slot_control.sv */
`default_nettype none
module tb_audio_link_slot_control
	import alsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] STATUS = 16'h5AC3;
	logic         sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, clr = 0;
	logic [9:0]   reg_addr = '0;
	logic [31:0]  reg_wdata = '0;
	logic [31:0]  reg_rdata;
	logic         irq, link_bit_clk, link_rx, link_tx, frame_sync_line, warm_restart_out, dma_sel;
	logic [239:0] acc;
	int           n_fail = 0, num_checks = 0, cyc = 0;
	alsc_top uut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.link_bit_clk, .link_rx, .link_tx, .frame_sync_line, .warm_restart_out, .dma_sel);
	alsc_codec_model #(.STATUS_WORD(STATUS)) codec (.link_bit_clk, .link_rx, .link_tx,
		.frame_sync_line, .warm_restart_out, .clr, .acc);
	always #5 sys_clk = ~sys_clk;
	// ----------
	// Tasks
	// ----------
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic cmp_val(logic [31:0] g, logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_frm(logic [239:0] g, logic [239:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(logic [9:0] a, logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdc(logic [9:0] a, logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 cmp_val(reg_rdata, e);
	endtask
	function automatic logic [19:0] word(int s);
		return {4'h9, 16'(s * 16'h1111)};
	endfunction
	function automatic logic [31:0] mp(int sa, int sb);
		return (32'h1 << 3 * (sa - 3)) | (32'h2 << 3 * (sb - 3));
	endfunction
	function automatic logic [239:0] frm(int sa, int sb, logic [19:0] da, db, logic [31:0] co);
		logic [239:0] f;
		f = '0;
		f[239-:20] = {co[23:16], 12'h000};
		f[219-:20] = {co[15:0], 4'h0};
		f[239 - 20 * (sa - 1)-:20] = da;
		f[239 - 20 * (sb - 1)-:20] = db;
		return f;
	endfunction
	initial begin
		logic [31:0] v, co;
		logic [19:0] da, db;
		int          sa, sb;
		v = $urandom(32'h29BEB446);
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge sys_clk);
		wr(OFS_ICA, 32'h0000_0249);
		rdc(OFS_ICA, 32'h0);
		rdc(OFS_IRQ_MASK, 32'h0);
		v = {29'h0, 1'($urandom), 2'h1};
		wr(OFS_MODE, v);
		rdc(OFS_MODE, v);
		rdc(OFS_ICA, 32'h0);
		v = $urandom & 32'h3FFF_FFFF;
		wr(OFS_ICA, v);
		rdc(OFS_ICA, v);
		wr(OFS_OCA, ~v & 32'h3FFF_FFFF);
		rdc(OFS_OCA, ~v & 32'h3FFF_FFFF);
		rdc(10'h060, 32'h0);
		rdc(OFS_DMA_LO, 32'h0);
		rdc(OFS_DMA_HI, 32'h0);
		wr(OFS_IRQ_SET, 32'hF);
		rdc(OFS_IRQ_MASK, 32'hF);
		wr(OFS_IRQ_CLR, 32'hE);
		rdc(OFS_IRQ_MASK, 32'h1);
		for (int i = 0; i < 4000 && irq !== 1'h1; i++) @(posedge sys_clk);
		cmp_val(32'(irq), 32'h1);
		rdc(OFS_GSTAT, 32'h1 << ST_SOF);
		cmp_val(32'(irq), 32'h0);
		wr(OFS_IRQ_CLR, 32'h1);
		repeat (3300) @(posedge sys_clk);
		cmp_val(32'(irq), 32'h0);
		for (int r = 0; r < 2; r++) begin
			sa = 3 + int'($urandom % 10);
			sb = 3 + (sa - 2 + int'($urandom % 9)) % 10;
			da = 20'($urandom);
			db = 20'($urandom);
			co = {8'h00, 1'(r), 7'($urandom), 16'($urandom)};
			wr(OFS_ICA, mp(sa, sb));
			wr(OFS_OCA, mp(sa, sb));
			wr(OFS_CA_TX, {12'h000, da});
			wr(OFS_CB_TX, {12'h000, db});
			clr <= 1'h1;
			wr(OFS_CO_TX, co);
			clr <= 1'h0;
			repeat (9900) @(posedge sys_clk);
			cmp_frm(acc, frm(sa, sb, da, db, co));
			rdc(OFS_CA_RX, {12'h000, word(sa)});
			rdc(OFS_CB_RX, {12'h000, word(sb)});
			rdc(OFS_CO_RX, {16'h0000, STATUS});
		end
		rdc(OFS_GSTAT, 32'hF);
		wr(OFS_MODE, 32'h3);
		repeat (WARM_CYC) @(posedge sys_clk);
		cmp_val({warm_restart_out, frame_sync_line}, 32'h3);
		wr(OFS_MODE, 32'h1);
		#1 cmp_val(32'(warm_restart_out), 32'h0);
		wr(OFS_MODE, 32'h0);
		repeat (200) @(posedge sys_clk);
		complete_run();
	end
endmodule
`default_nettype wire
